// [hdl/hosf_regs.vh]
// Register map, field positions, reset values and octet codes of the framer.
`ifndef HOSF_REGS_VH
`define HOSF_REGS_VH
`define HOSF_ADR_CTRL      8'h00
`define HOSF_ADR_STATUS    8'h04
`define HOSF_ADR_MASK      8'h08
`define HOSF_ADR_FCS_ERR   8'h0C
`define HOSF_ADR_TX_SAP_ID 8'h10
`define HOSF_ADR_RX_SAP_ID 8'h14
`define HOSF_ADR_MAX_RX_UNIT 8'h18
`define HOSF_ADR_LABELS    8'h1C
`define HOSF_CTRL_PPP      0
`define HOSF_CTRL_FCS16    1
`define HOSF_CTRL_SCR      2
`define HOSF_CTRL_LO_PATH  3
`define HOSF_CTRL_TX_EN    4
`define HOSF_ST_RX_GOOD    0
`define HOSF_ST_FCS_ERR    1
`define HOSF_ST_RX_DROP    2
`define HOSF_ST_UNDERRUN   3
`define HOSF_CTRL_RST      5'h00
`define HOSF_MASK_RST      4'h0
`define HOSF_MAX_RX_UNIT_RST 16'h05DC
`define HOSF_SAP_ID_RST    16'h0000
`define HOSF_FLAG          8'h7E
`define HOSF_ESC           8'h7D
`define HOSF_ESC_XOR       8'h20
`define HOSF_ADDR_NATIVE   8'h04
`define HOSF_ADDR_ALL      8'hFF
`define HOSF_CTRL_UI       8'h03
`define HOSF_HO_NATIVE     8'h18
`define HOSF_HO_PPP_SCR    8'h16
`define HOSF_HO_PPP_PLAIN  8'hCF
`define HOSF_LO_NATIVE     3'h5
`define HOSF_LO_OTHER      3'h0
`define HOSF_MIN_LEN32     16'h0006
`define HOSF_MIN_LEN16     16'h0004
`define HOSF_HDR_NATIVE    16'h0004
`define HOSF_HDR_PPP       16'h0002
`define HOSF_POLY32        32'hEDB88320
`define HOSF_POLY16        16'h8408
`define HOSF_RES32         32'hDEBB20E3
`define HOSF_RES16         16'hF0B8
`endif

// [hdl/hosf_crc.v]
// Reflected octet-wide check-sequence register, all ones after init.
`default_nettype none
module hosf_crc #(
    parameter             WIDTH = 32,
    parameter [WIDTH-1:0] POLY  = 32'hEDB88320
) (
    input  wire             clk_in,
    input  wire             rst_n_in,
    input  wire             init_in,
    input  wire             en_in,
    input  wire [7:0]       data_in,
    output reg  [WIDTH-1:0] crc_out
);
    reg [WIDTH-1:0] next_crc;
    integer         i;

    always @* begin
        next_crc = crc_out;
        for (i = 0; i < 8; i = i + 1) begin
            if (next_crc[0] ^ data_in[i]) begin
                next_crc = (next_crc >> 1) ^ POLY;
            end else begin
                next_crc = next_crc >> 1;
            end
        end
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            crc_out <= {WIDTH{1'b1}};
        end else if (init_in) begin
            crc_out <= {WIDTH{1'b1}};
        end else if (en_in) begin
            crc_out <= next_crc;
        end
    end
endmodule
`default_nettype wire

// [hdl/hosf_scr.v]
// Self-synchronous x^43+1 octet scrambler or descrambler, MSB sent first.
`default_nettype none
module hosf_scr #(
    parameter DESCR = 0
) (
    input  wire       clk_in,
    input  wire       rst_n_in,
    input  wire       en_in,
    input  wire       bypass_in,
    input  wire [7:0] data_in,
    output reg  [7:0] data_out,
    output reg        valid_out
);
    reg  [42:0] state;
    reg  [42:0] next_state;
    reg  [7:0]  next_data;
    reg         line_bit;
    integer     i;

    // The state always follows the line bits, so bypass can toggle without a resync hit.
    always @* begin
        next_state = state;
        next_data  = 8'h00;
        line_bit   = 1'b0;
        for (i = 7; i >= 0; i = i - 1) begin
            next_data[i] = bypass_in ? data_in[i] : (data_in[i] ^ next_state[42]);
            line_bit     = (DESCR != 0) ? data_in[i] : next_data[i];
            next_state   = {next_state[41:0], line_bit};
        end
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state     <= 43'h0;
            data_out  <= 8'h00;
            valid_out <= 1'b0;
        end else begin
            valid_out <= en_in;
            if (en_in) begin
                state    <= next_state;
                data_out <= next_data;
            end
        end
    end
endmodule
`default_nettype wire

// [hdl/hosf_framer.v]
// Octet-synchronous framer and deframer with a Wishbone register file.
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`include "hosf_regs.vh"
`default_nettype none
// Behaviour
// - Native uses 32-bit check sequence; PPP mode selects 16 or 32.
// - Transmitter escapes flag and escape octets inside frame contents.
// - Native receive drops frames shorter than six octets.
// - Native receive drops frames ending before the control field.
// - PPP receive with 16-bit check drops frames under four octets.
// - PPP receive drops frames whose last octet before the flag is escape.
// - Receive drops frames with a zero stop bit.
// - Length, termination and framing drops do not count as check errors.
// - Idle time between frames is filled with flags.
// - Native always scrambles; high-order label is 0x18.
// - Native on lower-order path sends low-order label 101.
// - PPP scrambling optional; label 0x16 when on, 0xCF when off.
// - Native frame: flag, 0x04, 0x03, two-octet id, data, check, flag.
// - One-octet address; accept 0xFF or own 0x04 (native mode only), discard others.
// - Native octets after control are the service access point id.
module hosf_framer (
    input  wire        SYS_CLK_IN,
    input  wire        RESET_N_IN,
    input  wire        WB_CYC_IN,
    input  wire        WB_STB_IN,
    input  wire        WB_WE_IN,
    input  wire [7:0]  WB_ADR_IN,
    input  wire [3:0]  WB_SEL_IN,
    input  wire [31:0] WB_DAT_IN,
    output reg  [31:0] WB_DAT_OUT,
    output reg         WB_ACK_OUT,
    output reg         IRQ_OUT,
    input  wire [7:0]  TX_DATA_IN,
    input  wire        TX_VALID_IN,
    input  wire        TX_LAST_IN,
    output reg         TX_READY_OUT,
    input  wire        LINE_TX_REQ_IN,
    output wire [7:0]  LINE_TX_DATA_OUT,
    output wire        LINE_TX_VALID_OUT,
    input  wire [7:0]  LINE_RX_DATA_IN,
    input  wire        LINE_RX_VALID_IN,
    input  wire        LINE_RX_STOP_IN,
    output reg  [7:0]  RX_DATA_OUT,
    output reg         RX_VALID_OUT,
    output reg         RX_END_OUT,
    output reg         RX_GOOD_OUT,
    output reg  [15:0] RX_SERVICE_ACCESS_POINT_ID_OUT,
    output reg  [7:0]  HIGH_ORDER_PATH_LABEL_OUT,
    output reg  [2:0]  LOW_ORDER_PATH_LABEL_OUT
);
    localparam [7:0] S_IDLE  = 8'h01;
    localparam [7:0] S_ADDR  = 8'h02;
    localparam [7:0] S_CTRL  = 8'h04;
    localparam [7:0] S_SAPH  = 8'h08;
    localparam [7:0] S_SAPL  = 8'h10;
    localparam [7:0] S_DATA  = 8'h20;
    localparam [7:0] S_FCS   = 8'h40;
    localparam [7:0] S_CLOSE = 8'h80;

    reg  [4:0]  ctrl;
    reg  [3:0]  status;
    reg  [3:0]  mask;
    reg  [15:0] fcs_err_cnt;
    reg  [15:0] tx_sap_id;
    reg  [15:0] max_rx_unit;
    wire        native = !ctrl[`HOSF_CTRL_PPP];
    wire        fcs16  = ctrl[`HOSF_CTRL_PPP] & ctrl[`HOSF_CTRL_FCS16];
    wire        scr_on = native | ctrl[`HOSF_CTRL_SCR];
    wire [15:0] hdr    = native ? `HOSF_HDR_NATIVE : `HOSF_HDR_PPP;
    wire [15:0] fcsn   = fcs16 ? 16'h0002 : 16'h0004;

    // Register bus: one wait state, every access answered.
    wire        wb_req = WB_CYC_IN & WB_STB_IN & !WB_ACK_OUT;
    wire        wb_wr  = wb_req & WB_WE_IN;
    wire [15:0] wmask  = {{8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
    wire        st_rd  = wb_req & !WB_WE_IN & (WB_ADR_IN == `HOSF_ADR_STATUS);
    reg  [3:0]  ev;
    reg  [31:0] rd_mux;

    always @* begin
        case (WB_ADR_IN)
            `HOSF_ADR_CTRL:    rd_mux = {27'h0, ctrl};
            `HOSF_ADR_STATUS:  rd_mux = {28'h0, status};
            `HOSF_ADR_MASK:    rd_mux = {28'h0, mask};
            `HOSF_ADR_FCS_ERR: rd_mux = {16'h0, fcs_err_cnt};
            `HOSF_ADR_TX_SAP_ID: rd_mux = {16'h0, tx_sap_id};
            `HOSF_ADR_RX_SAP_ID: rd_mux = {16'h0, RX_SERVICE_ACCESS_POINT_ID_OUT};
            `HOSF_ADR_MAX_RX_UNIT: rd_mux = {16'h0, max_rx_unit};
            `HOSF_ADR_LABELS:  rd_mux = {21'h0, LOW_ORDER_PATH_LABEL_OUT,
                                         HIGH_ORDER_PATH_LABEL_OUT};
            default:           rd_mux = 32'h0;
        endcase
    end

    always @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= 32'h0;
            ctrl       <= `HOSF_CTRL_RST;
            mask       <= `HOSF_MASK_RST;
            tx_sap_id  <= `HOSF_SAP_ID_RST;
            max_rx_unit <= `HOSF_MAX_RX_UNIT_RST;
            status     <= 4'h0;
            IRQ_OUT    <= 1'b0;
            HIGH_ORDER_PATH_LABEL_OUT <= `HOSF_HO_NATIVE;
            LOW_ORDER_PATH_LABEL_OUT  <= `HOSF_LO_OTHER;
        end else begin
            WB_ACK_OUT <= wb_req;
            if (wb_req) begin
                WB_DAT_OUT <= WB_WE_IN ? 32'h0 : rd_mux;
            end
            if (wb_wr && WB_SEL_IN[0]) begin
                if (WB_ADR_IN == `HOSF_ADR_CTRL) begin
                    ctrl <= WB_DAT_IN[4:0];
                end
                if (WB_ADR_IN == `HOSF_ADR_MASK) begin
                    mask <= WB_DAT_IN[3:0];
                end
            end
            if (wb_wr && WB_ADR_IN == `HOSF_ADR_TX_SAP_ID) begin
                tx_sap_id <= (tx_sap_id & ~wmask) | (WB_DAT_IN[15:0] & wmask);
            end
            if (wb_wr && WB_ADR_IN == `HOSF_ADR_MAX_RX_UNIT) begin
                max_rx_unit <= (max_rx_unit & ~wmask) | (WB_DAT_IN[15:0] & wmask);
            end
            // A read clears the flags, but an event in that same cycle still lands.
            status  <= (st_rd ? 4'h0 : status) | ev;
            IRQ_OUT <= |(((st_rd ? 4'h0 : status) | ev) & mask);
            if (native) begin
                HIGH_ORDER_PATH_LABEL_OUT <= `HOSF_HO_NATIVE;
            end else begin
                HIGH_ORDER_PATH_LABEL_OUT <= scr_on ? `HOSF_HO_PPP_SCR
                                                    : `HOSF_HO_PPP_PLAIN;
            end
            LOW_ORDER_PATH_LABEL_OUT <= (native && ctrl[`HOSF_CTRL_LO_PATH])
                                        ? `HOSF_LO_NATIVE : `HOSF_LO_OTHER;
        end
    end

    // Transmit: one holding octet in front of the framing state machine.
    reg  [7:0]  tx_state;
    reg  [7:0]  hold;
    reg         hold_last;
    reg         hold_full;
    reg         esc_pend;
    reg  [7:0]  esc_byte;
    reg         abort_pend;
    reg  [1:0]  fcs_idx;
    reg  [7:0]  next_state;
    reg  [7:0]  content;
    reg  [7:0]  line_oct;
    reg         crc_en;
    reg         consume;
    reg         underrun;
    wire [31:0] tx_crc32;
    wire [15:0] tx_crc16;
    wire [31:0] tx_fcs = fcs16 ? {16'h0, ~tx_crc16} : ~tx_crc32;
    wire        take   = TX_READY_OUT & TX_VALID_IN;
    wire        tx_init = LINE_TX_REQ_IN & (tx_state == S_IDLE);

    always @* begin
        next_state = tx_state;
        content    = `HOSF_FLAG;
        crc_en     = 1'b0;
        consume    = 1'b0;
        underrun   = 1'b0;
        case (tx_state)
            S_IDLE: begin
                if (ctrl[`HOSF_CTRL_TX_EN] && hold_full) begin
                    next_state = S_ADDR;
                end
            end
            S_ADDR: begin
                content    = native ? `HOSF_ADDR_NATIVE : `HOSF_ADDR_ALL;
                crc_en     = 1'b1;
                next_state = S_CTRL;
            end
            S_CTRL: begin
                content    = `HOSF_CTRL_UI;
                crc_en     = 1'b1;
                next_state = native ? S_SAPH : S_DATA;
            end
            S_SAPH: begin
                content    = tx_sap_id[15:8];
                crc_en     = 1'b1;
                next_state = S_SAPL;
            end
            S_SAPL: begin
                content    = tx_sap_id[7:0];
                crc_en     = 1'b1;
                next_state = S_DATA;
            end
            S_DATA: begin
                if (hold_full) begin
                    content    = hold;
                    crc_en     = 1'b1;
                    consume    = 1'b1;
                    next_state = hold_last ? S_FCS : S_DATA;
                end else begin
                    // Starved mid-frame: send escape then flag so the far end drops it.
                    content    = `HOSF_ESC;
                    underrun   = 1'b1;
                    next_state = S_CLOSE;
                end
            end
            S_FCS: begin
                content = tx_fcs[8*fcs_idx +: 8];
                if ({14'h0, fcs_idx} == fcsn - 16'h0001) begin
                    next_state = S_CLOSE;
                end
            end
            S_CLOSE: begin
                next_state = S_IDLE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    wire need_esc = (content == `HOSF_FLAG || content == `HOSF_ESC) && !underrun &&
                    tx_state != S_IDLE && tx_state != S_CLOSE;

    always @* begin
        if (esc_pend) begin
            line_oct = esc_byte;
        end else if (need_esc) begin
            line_oct = `HOSF_ESC;
        end else begin
            line_oct = content;
        end
    end

    always @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            tx_state     <= S_IDLE;
            hold         <= 8'h00;
            hold_last    <= 1'b0;
            hold_full    <= 1'b0;
            TX_READY_OUT <= 1'b1;
            esc_pend     <= 1'b0;
            esc_byte     <= 8'h00;
            abort_pend   <= 1'b0;
            fcs_idx      <= 2'h0;
        end else begin
            abort_pend <= 1'b0;
            if (take) begin
                hold      <= TX_DATA_IN;
                hold_last <= TX_LAST_IN;
            end
            if (LINE_TX_REQ_IN && esc_pend) begin
                esc_pend <= 1'b0;
            end else if (LINE_TX_REQ_IN) begin
                tx_state <= next_state;
                esc_pend <= need_esc;
                esc_byte <= content ^ `HOSF_ESC_XOR;
                abort_pend <= underrun;
                fcs_idx  <= (tx_state == S_FCS) ? fcs_idx + 2'h1 : 2'h0;
            end
            hold_full    <= take | (hold_full & !(consume & LINE_TX_REQ_IN & !esc_pend));
            TX_READY_OUT <= !(take | (hold_full & !(consume & LINE_TX_REQ_IN & !esc_pend)));
        end
    end

    wire tx_crc_en = LINE_TX_REQ_IN & !esc_pend & crc_en;

    hosf_crc #(.WIDTH(32), .POLY(`HOSF_POLY32)) u_tx_crc32 (
        .clk_in(SYS_CLK_IN), .rst_n_in(RESET_N_IN), .init_in(tx_init),
        .en_in(tx_crc_en), .data_in(content), .crc_out(tx_crc32));
    hosf_crc #(.WIDTH(16), .POLY(`HOSF_POLY16)) u_tx_crc16 (
        .clk_in(SYS_CLK_IN), .rst_n_in(RESET_N_IN), .init_in(tx_init),
        .en_in(tx_crc_en), .data_in(content), .crc_out(tx_crc16));

    // Scrambling covers flags too, so the line never shows long fixed runs.
    hosf_scr #(.DESCR(0)) u_tx_scr (
        .clk_in(SYS_CLK_IN), .rst_n_in(RESET_N_IN), .en_in(LINE_TX_REQ_IN),
        .bypass_in(!scr_on), .data_in(line_oct),
        .data_out(LINE_TX_DATA_OUT), .valid_out(LINE_TX_VALID_OUT));

    // Receive: descramble, then hunt for flags and undo escaping.
    wire [7:0]  rx_d;
    wire        rx_dv;
    reg         rx_stop;
    reg         in_frame;
    reg         rx_escp;
    reg         rx_bad;
    reg         rx_addr_bad;
    reg  [15:0] rx_len;
    reg  [31:0] rx_sh;
    reg  [15:0] rx_sap_id;
    wire [31:0] rx_crc32;
    wire [15:0] rx_crc16;

    hosf_scr #(.DESCR(1)) u_rx_scr (
        .clk_in(SYS_CLK_IN), .rst_n_in(RESET_N_IN), .en_in(LINE_RX_VALID_IN),
        .bypass_in(!scr_on), .data_in(LINE_RX_DATA_IN),
        .data_out(rx_d), .valid_out(rx_dv));

    wire        rx_flag = rx_dv & (rx_d == `HOSF_FLAG);
    wire        rx_data = rx_dv & in_frame & !rx_flag & (rx_escp | (rx_d != `HOSF_ESC));
    wire [7:0]  rx_oct  = rx_escp ? (rx_d ^ `HOSF_ESC_XOR) : rx_d;
    wire        bad_now = rx_bad | (rx_dv & !rx_stop);
    wire        too_short = rx_len < (fcs16 ? `HOSF_MIN_LEN16 : `HOSF_MIN_LEN32);
    wire        no_ctrl = native & (rx_len < 16'h0002);
    wire        rx_drop = too_short | no_ctrl | rx_escp | bad_now | rx_addr_bad |
                          (rx_len > max_rx_unit + hdr + fcsn);
    wire        res_ok  = fcs16 ? (rx_crc16 == `HOSF_RES16) : (rx_crc32 == `HOSF_RES32);
    wire        rx_end  = rx_flag & in_frame & (rx_len != 16'h0000);
    wire        fcs_bad = rx_end & !rx_drop & !res_ok;
    wire        rx_ok   = rx_end & !rx_drop & res_ok;

    always @* begin
        ev = 4'h0;
        ev[`HOSF_ST_RX_GOOD]  = rx_ok;
        ev[`HOSF_ST_FCS_ERR]  = fcs_bad;
        ev[`HOSF_ST_RX_DROP]  = rx_end & rx_drop;
        ev[`HOSF_ST_UNDERRUN] = abort_pend;
    end

    hosf_crc #(.WIDTH(32), .POLY(`HOSF_POLY32)) u_rx_crc32 (
        .clk_in(SYS_CLK_IN), .rst_n_in(RESET_N_IN), .init_in(rx_flag),
        .en_in(rx_data), .data_in(rx_oct), .crc_out(rx_crc32));
    hosf_crc #(.WIDTH(16), .POLY(`HOSF_POLY16)) u_rx_crc16 (
        .clk_in(SYS_CLK_IN), .rst_n_in(RESET_N_IN), .init_in(rx_flag),
        .en_in(rx_data), .data_in(rx_oct), .crc_out(rx_crc16));

    always @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rx_stop      <= 1'b1;
            in_frame     <= 1'b0;
            rx_escp      <= 1'b0;
            rx_bad       <= 1'b0;
            rx_addr_bad  <= 1'b0;
            rx_len       <= 16'h0000;
            rx_sh        <= 32'h0;
            rx_sap_id    <= 16'h0000;
            fcs_err_cnt  <= 16'h0000;
            RX_DATA_OUT  <= 8'h00;
            RX_VALID_OUT <= 1'b0;
            RX_END_OUT   <= 1'b0;
            RX_GOOD_OUT  <= 1'b0;
            RX_SERVICE_ACCESS_POINT_ID_OUT <= 16'h0000;
        end else begin
            if (LINE_RX_VALID_IN) begin
                rx_stop <= LINE_RX_STOP_IN;
            end
            RX_VALID_OUT <= 1'b0;
            RX_END_OUT   <= 1'b0;
            if (fcs_bad) begin
                fcs_err_cnt <= fcs_err_cnt + 16'h0001;
            end
            if (rx_flag) begin
                in_frame    <= 1'b1;
                rx_escp     <= 1'b0;
                rx_bad      <= 1'b0;
                rx_addr_bad <= 1'b0;
                rx_len      <= 16'h0000;
                if (rx_end) begin
                    RX_END_OUT  <= 1'b1;
                    RX_GOOD_OUT <= rx_ok;
                    if (rx_ok) begin
                        RX_SERVICE_ACCESS_POINT_ID_OUT <= native ? rx_sap_id : 16'h0000;
                    end
                end
            end else if (rx_dv && in_frame) begin
                rx_bad  <= bad_now;
                rx_escp <= !rx_escp & (rx_d == `HOSF_ESC);
                if (rx_data) begin
                    rx_len <= (rx_len == 16'hFFFF) ? rx_len : rx_len + 16'h0001;
                    rx_sh  <= {rx_sh[23:0], rx_oct};
                    if (rx_len == 16'h0000) begin
                        rx_addr_bad <= (rx_oct != `HOSF_ADDR_ALL) &&
                                       !(native && rx_oct == `HOSF_ADDR_NATIVE);
                    end
                    if (rx_len == 16'h0002) begin
                        rx_sap_id[15:8] <= rx_oct;
                    end
                    if (rx_len == 16'h0003) begin
                        rx_sap_id[7:0] <= rx_oct;
                    end
                    // Data leaves only once the trailing check octets are known.
                    // A pending escape here is part of this octet, not a reason to hold data.
                    if (rx_len >= hdr + fcsn && !bad_now && !rx_addr_bad) begin
                        RX_VALID_OUT <= 1'b1;
                        RX_DATA_OUT  <= fcs16 ? rx_sh[15:8] : rx_sh[31:24];
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// [tb/hosf_framer_assertions.sv]
// Port-level checks for the framer.
`default_nettype none
module hosf_framer_assertions (
    input wire logic       SYS_CLK_IN,
    input wire logic       RESET_N_IN,
    input wire logic       WB_CYC_IN,
    input wire logic       WB_STB_IN,
    input wire logic       WB_ACK_OUT,
    input wire logic       TX_VALID_IN,
    input wire logic       TX_READY_OUT,
    input wire logic       LINE_TX_REQ_IN,
    input wire logic       LINE_TX_VALID_OUT,
    input wire logic       RX_END_OUT,
    input wire logic [7:0] HIGH_ORDER_PATH_LABEL_OUT,
    input wire logic [2:0] LOW_ORDER_PATH_LABEL_OUT
);
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);
    chk_ack_one: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("ack longer than one cycle");
    chk_ack_answer: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
        else $error("ack late");
    chk_line_answer: assert property (LINE_TX_REQ_IN |=> LINE_TX_VALID_OUT)
        else $error("line octet missing");
    chk_line_cause: assert property (LINE_TX_VALID_OUT |-> $past(LINE_TX_REQ_IN))
        else $error("line octet unrequested");
    chk_ready_take: assert property (TX_READY_OUT && TX_VALID_IN |=> !TX_READY_OUT)
        else $error("ready stayed after take");
    chk_end_pulse: assert property (RX_END_OUT |=> !RX_END_OUT)
        else $error("end longer than one cycle");
    chk_ho_code: assert property (HIGH_ORDER_PATH_LABEL_OUT inside {8'h18, 8'h16, 8'hCF})
        else $error("bad high-order label");
    chk_lo_native: assert property (LOW_ORDER_PATH_LABEL_OUT != 3'h0 |->
        LOW_ORDER_PATH_LABEL_OUT == 3'h5 && HIGH_ORDER_PATH_LABEL_OUT == 8'h18)
        else $error("bad low-order label");
endmodule
bind hosf_framer hosf_framer_assertions chk_i (
    .SYS_CLK_IN(SYS_CLK_IN), .RESET_N_IN(RESET_N_IN), .WB_CYC_IN(WB_CYC_IN),
    .WB_STB_IN(WB_STB_IN), .WB_ACK_OUT(WB_ACK_OUT), .TX_VALID_IN(TX_VALID_IN),
    .TX_READY_OUT(TX_READY_OUT), .LINE_TX_REQ_IN(LINE_TX_REQ_IN),
    .LINE_TX_VALID_OUT(LINE_TX_VALID_OUT), .RX_END_OUT(RX_END_OUT),
    .HIGH_ORDER_PATH_LABEL_OUT(HIGH_ORDER_PATH_LABEL_OUT),
    .LOW_ORDER_PATH_LABEL_OUT(LOW_ORDER_PATH_LABEL_OUT));
`default_nettype wire

// [tb/hosf_line_model.sv]
// Path mapper model: pulls line octets and loops them back to the receiver.
`default_nettype none
module hosf_line_model (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       slow_in,
    input  wire logic       bad_stop_in,
    input  wire logic [7:0] tx_data_in,
    input  wire logic       tx_valid_in,
    output logic            req_out,
    output logic [7:0]      rx_data_out,
    output logic            rx_valid_out,
    output logic            rx_stop_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] gap;
    // Between octets the data lines flip, so a stale octet is never reused.
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gap <= 2'h0;
            req_out <= 1'b0;
            rx_valid_out <= 1'b0;
            rx_data_out <= 8'h00;
            rx_stop_out <= 1'b1;
        end else begin
            gap <= gap + 2'h1;
            req_out <= slow_in ? (gap == 2'h3) : ~req_out;
            rx_valid_out <= tx_valid_in;
            rx_data_out <= tx_valid_in ? tx_data_in : ~rx_data_out;
            rx_stop_out <= ~(bad_stop_in & tx_valid_in);
        end
    end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Loopback bench: register accesses, packet sends and receive checks.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, cyc, stb, we, ack, irq, tx_valid, tx_last, ready;
    logic        req, lvalid, rvalid, rstop, rxv, rxe, rxg, slow, bad_stop, good;
    logic [7:0]  adr, tx_data, ldata, rdata, rxd, ho;
    logic [2:0]  lo;
    logic [15:0] sid;
    logic [31:0] wdat, rdat, q;
    logic [7:0]  rxq[$];
    logic [31:0] modes[4] = '{32'h13, 32'h17, 32'h11, 32'h18};
    logic [31:0] labels[4] = '{32'hCF, 32'h16, 32'hCF, 32'h518};
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          ends = 0;
    hosf_framer dut (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .IRQ_OUT(irq), .TX_DATA_IN(tx_data), .TX_VALID_IN(tx_valid),
        .TX_LAST_IN(tx_last), .TX_READY_OUT(ready), .LINE_TX_REQ_IN(req),
        .LINE_TX_DATA_OUT(ldata), .LINE_TX_VALID_OUT(lvalid), .LINE_RX_DATA_IN(rdata),
        .LINE_RX_VALID_IN(rvalid), .LINE_RX_STOP_IN(rstop), .RX_DATA_OUT(rxd),
        .RX_VALID_OUT(rxv), .RX_END_OUT(rxe), .RX_GOOD_OUT(rxg),
        .RX_SERVICE_ACCESS_POINT_ID_OUT(sid),
        .HIGH_ORDER_PATH_LABEL_OUT(ho), .LOW_ORDER_PATH_LABEL_OUT(lo));
    hosf_line_model line (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow),
        .bad_stop_in(bad_stop), .tx_data_in(ldata), .tx_valid_in(lvalid), .req_out(req),
        .rx_data_out(rdata), .rx_valid_out(rvalid), .rx_stop_out(rstop));
    // The end count moves by non-blocking update, so waits never race the sink.
    always @(posedge clk) begin
        if (rxv === 1'b1)
            rxq.push_back(rxd);
        if (rxe === 1'b1) begin
            ends <= ends + 1;
            good <= rxg;
        end
    end
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tmo(input int i);
        if (i >= 3000) begin
            chk("timeout", 32'h0, 32'h1);
            give_verdict();
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'b1 && i < 3000);
        tmo(i);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, q);
    endtask
    task automatic frame(input logic [7:0] p[$], input logic g);
        int i;
        int e0;
        rxq = {};
        e0 = ends;
        foreach (p[k]) begin
            tx_data <= p[k];
            tx_valid <= 1'b1;
            tx_last <= (k == p.size() - 1);
            i = 0;
            do begin
                @(posedge clk);
                i++;
            end while (ready !== 1'b1 && i < 3000);
            tmo(i);
        end
        tx_valid <= 1'b0;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ends == e0 && i < 3000);
        tmo(i);
        chk("good", {31'h0, g}, {31'h0, good});
        if (g) begin
            chk("count", p.size(), rxq.size());
            foreach (p[k]) chk("payload", {24'h0, p[k]}, {24'h0, rxq[k]});
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rst_n, cyc, stb, we, tx_valid, tx_last, slow, bad_stop} = 8'h00;
        {adr, tx_data, wdat} = 48'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(8'h00, 32'h0);
        rd(8'h18, 32'h5DC);
        rd(8'h1C, 32'h18);
        wb(1'b1, 8'h40, 32'hFF);
        rd(8'h40, 32'h0);
        wb(1'b1, 8'h08, 32'h1);
        wb(1'b1, 8'h10, 32'h1234);
        wb(1'b1, 8'h00, 32'h10);
        repeat (60) @(posedge clk);
        frame('{8'h7E, 8'h7D, 8'h5A}, 1'b1);
        chk("sap id", 32'h1234, {16'h0, sid});
        @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        rd(8'h04, 32'h1);
        rd(8'h04, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        bad_stop <= 1'b1;
        frame('{8'h11, 8'h22, 8'h33}, 1'b0);
        bad_stop <= 1'b0;
        rd(8'h04, 32'h4);
        rd(8'h0C, 32'h0);
        // Idle flags after each mode change let the descrambler resynchronise.
        foreach (modes[k]) begin
            wb(1'b1, 8'h00, modes[k]);
            slow <= k[0];
            repeat (60) @(posedge clk);
            rd(8'h1C, labels[k]);
            chk("labels", labels[k], {21'h0, lo, ho});
            frame('{8'h00, 8'h21, 8'h7E, 8'h7D}, 1'b1);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
